// File: common/pwp_pkg.sv
// Constants shared by the peripheral write-protect controller
package pwp_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int PWP_DATA_W = 32;
  localparam int PWP_ADDR_W = 8;
  localparam int PWP_STRB_W = PWP_DATA_W / 8;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [PWP_ADDR_W-1:0] PWP_OFF_CLEAR = 8'h00;
  localparam logic [PWP_ADDR_W-1:0] PWP_OFF_SET   = 8'h04;

  // ---------------------------------------------------------------
  // Reset values and implemented bits
  // ---------------------------------------------------------------
  localparam logic [PWP_DATA_W-1:0] PWP_G0_RESET = 32'h0000_0000;
  localparam logic [PWP_DATA_W-1:0] PWP_G1_RESET = 32'h0000_0002;
  localparam logic [PWP_DATA_W-1:0] PWP_G0_MASK  = 32'h0000_007e;
  localparam logic [PWP_DATA_W-1:0] PWP_G1_MASK  = 32'h0000_004e;

  // ---------------------------------------------------------------
  // Field positions, group 0
  // ---------------------------------------------------------------
  localparam int PWP_G0_IRQ_LINE_BIT = 6;
  localparam int PWP_G0_CALENDAR_BIT = 5;
  localparam int PWP_G0_WATCHDOG_BIT = 4;
  localparam int PWP_G0_CLOCK_GEN_BIT = 3;
  localparam int PWP_G0_SYS_CTRL_BIT = 2;
  localparam int PWP_G0_POWER_BIT    = 1;

  // ---------------------------------------------------------------
  // Field positions, group 1
  // ---------------------------------------------------------------
  localparam int PWP_G1_TRACE_BIT    = 6;
  localparam int PWP_G1_IO_PORT_BIT  = 3;
  localparam int PWP_G1_FLASH_BIT    = 2;
  localparam int PWP_G1_DEBUG_BIT    = 1;

  // ---------------------------------------------------------------
  // Decoded access target, latched in the setup phase
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PWP_TGT_NONE   = 2'b00,
    PWP_TGT_G0_CLR = 2'b01,
    PWP_TGT_G0_SET = 2'b10,
    PWP_TGT_G1_CLR = 2'b11
  } pwp_target_t;

endpackage : pwp_pkg

// File: common/pwp_grp_if.sv
// Connection between the bus front end and one protection group
`timescale 1ns/1ps
`default_nettype none

interface pwp_grp_if;
  import pwp_pkg::*;

  logic                  wr_clear;
  logic                  wr_set;
  logic [PWP_DATA_W-1:0] wdata;
  logic [PWP_DATA_W-1:0] state;

  modport ctrl (output wr_clear, output wr_set, output wdata, input state);
  modport grp  (input wr_clear, input wr_set, input wdata, output state);
endinterface : pwp_grp_if

`default_nettype wire

// File: src/pwp_group.sv
// One group of peripheral write-protection bits
`timescale 1ns/1ps
`default_nettype none

module pwp_group #(
  parameter logic [pwp_pkg::PWP_DATA_W-1:0] RESET_VAL  = 32'h0000_0000,
  parameter logic [pwp_pkg::PWP_DATA_W-1:0] VALID_MASK = 32'h0000_007e,
  parameter bit                             HAS_SET    = 1'b1
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  pwp_grp_if.grp    bus
);
  import pwp_pkg::*;

  logic [PWP_DATA_W-1:0] state_reg;

  // zero ignored: only one-bits of wdata touch the state
  // clear removes protection; set enables protection
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= RESET_VAL;
    end else if (bus.wr_set && HAS_SET) begin
      state_reg <= (state_reg | bus.wdata) & VALID_MASK;
    end else if (bus.wr_clear) begin
      state_reg <= state_reg & ~bus.wdata & VALID_MASK;
    end
  end

  // Unused positions always read zero
  assign bus.state = state_reg;

endmodule : pwp_group

`default_nettype wire

// File: src/pwp_top.sv
// Peripheral write-protect controller with two protection groups
`timescale 1ns/1ps
`default_nettype none

module pwp_top (
  input  wire logic                              ref_clk,
  input  wire logic                              sys_rst,
  input  wire logic                              psel_grp0,
  input  wire logic                              psel_grp1,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [pwp_pkg::PWP_ADDR_W-1:0]    paddr,
  input  wire logic [pwp_pkg::PWP_DATA_W-1:0]    pwdata,
  input  wire logic [pwp_pkg::PWP_STRB_W-1:0]    pstrb,
  output logic      [pwp_pkg::PWP_DATA_W-1:0]    prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  output logic      [pwp_pkg::PWP_DATA_W-1:0]    group0_protect,
  output logic      [pwp_pkg::PWP_DATA_W-1:0]    group1_protect,
  output logic                                   irq_line_ctrl_prot,
  output logic                                   calendar_prot,
  output logic                                   watchdog_prot,
  output logic                                   clock_gen_prot,
  output logic                                   system_control_prot,
  output logic                                   power_manager_prot,
  output logic                                   trace_buffer_prot,
  output logic                                   io_port_prot,
  output logic                                   flash_ctrl_prot,
  output logic                                   debug_service_prot
);
  import pwp_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic offset_hit(
    input logic [PWP_ADDR_W-1:0] addr,
    input logic [PWP_ADDR_W-1:0] offset
  );
    offset_hit = (addr == offset);
  endfunction : offset_hit

  // Byte strobes widened to a bit mask; a dead lane writes only zeros,
  // which by construction can change nothing
  function automatic logic [PWP_DATA_W-1:0] lane_mask(
    input logic [PWP_STRB_W-1:0] strb
  );
    logic [PWP_DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < PWP_STRB_W; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    lane_mask = m;
  endfunction : lane_mask

  // ---------------------------------------------------------------
  // Group instances
  // ---------------------------------------------------------------
  pwp_grp_if g0_if ();
  pwp_grp_if g1_if ();

  // group 0 resets to zero; its implemented bits
  pwp_group #(
    .RESET_VAL  (PWP_G0_RESET),
    .VALID_MASK (PWP_G0_MASK),
    .HAS_SET    (1'b1)
  ) u_group0 (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .bus     (g0_if.grp)
  );

  // group 1 resets with debug service protected; its bits
  pwp_group #(
    .RESET_VAL  (PWP_G1_RESET),
    .VALID_MASK (PWP_G1_MASK),
    .HAS_SET    (1'b0)
  ) u_group1 (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .bus     (g1_if.grp)
  );

  // ---------------------------------------------------------------
  // Setup phase: decode and read data captured into flops
  // ---------------------------------------------------------------
  logic                  setup_phase;
  logic                  access_phase;
  logic                  both_sel;
  logic                  sel0_only;
  logic                  sel1_only;
  pwp_target_t           target_next;
  pwp_target_t           target_reg;
  logic [PWP_DATA_W-1:0] prdata_next;
  logic [PWP_DATA_W-1:0] prdata_reg;
  logic                  pslverr_next;
  logic                  pslverr_reg;

  assign setup_phase  = (psel_grp0 | psel_grp1) & ~penable;
  assign access_phase = (psel_grp0 | psel_grp1) & penable;
  assign both_sel     = psel_grp0 & psel_grp1;
  // Both selects high is a far-side fault; neither window claims it
  assign sel0_only    = psel_grp0 & ~both_sel;
  assign sel1_only    = psel_grp1 & ~both_sel;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // clear at 0x00 and set at 0x04; group 1 has only the clear word
  always_comb begin
    target_next = PWP_TGT_NONE;
    if (sel0_only && offset_hit(paddr, PWP_OFF_CLEAR)) begin
      target_next = PWP_TGT_G0_CLR;
    end else if (sel0_only && offset_hit(paddr, PWP_OFF_SET)) begin
      target_next = PWP_TGT_G0_SET;
    end else if (sel1_only && offset_hit(paddr, PWP_OFF_CLEAR)) begin
      target_next = PWP_TGT_G1_CLR;
    end
  end

  // ---------------------------------------------------------------
  // Read data and error response
  // ---------------------------------------------------------------
  // both words read the live state: 1 means protected
  always_comb begin
    prdata_next = '0;
    unique case (target_next)
      PWP_TGT_NONE:   prdata_next = '0;
      PWP_TGT_G0_CLR: prdata_next = g0_if.state;
      PWP_TGT_G0_SET: prdata_next = g0_if.state;
      PWP_TGT_G1_CLR: prdata_next = g1_if.state;
    endcase
  end

  // Unmapped words and reads that carry byte strobes answer with an error
  assign pslverr_next = (target_next == PWP_TGT_NONE) |
                        (~pwrite & (|pstrb));

  // Refused accesses latch no target, so their access phase writes nothing
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      target_reg <= PWP_TGT_NONE;
    end else if (setup_phase) begin
      target_reg <= pslverr_next ? PWP_TGT_NONE : target_next;
    end
  end

  // Captured at setup so the access phase drives read data from a flop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata_reg <= '0;
    end else if (setup_phase) begin
      prdata_reg <= (pwrite || pslverr_next) ? '0 : prdata_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= pslverr_next;
    end
  end

  // Zero wait states: every access phase completes at once
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

  // ---------------------------------------------------------------
  // Access phase: one-cycle write strobes into the groups
  // ---------------------------------------------------------------
  logic                  wr_go;
  logic [PWP_DATA_W-1:0] wr_bits;

  // A refused access never strobes either group
  assign wr_go   = access_phase & pwrite & ~pslverr_reg;
  // zero bits and dead byte lanes carry no change
  assign wr_bits = pwdata & lane_mask(pstrb);

  assign g0_if.wr_clear = wr_go & (target_reg == PWP_TGT_G0_CLR);
  assign g0_if.wr_set   = wr_go & (target_reg == PWP_TGT_G0_SET);
  assign g0_if.wdata    = wr_bits;

  assign g1_if.wr_clear = wr_go & (target_reg == PWP_TGT_G1_CLR);
  assign g1_if.wr_set   = 1'b0;
  assign g1_if.wdata    = wr_bits;

  // ---------------------------------------------------------------
  // Protection outputs toward the peripherals
  // ---------------------------------------------------------------
  assign group0_protect = g0_if.state;
  assign group1_protect = g1_if.state;

  assign irq_line_ctrl_prot  = g0_if.state[PWP_G0_IRQ_LINE_BIT];
  assign calendar_prot       = g0_if.state[PWP_G0_CALENDAR_BIT];
  assign watchdog_prot       = g0_if.state[PWP_G0_WATCHDOG_BIT];
  assign clock_gen_prot      = g0_if.state[PWP_G0_CLOCK_GEN_BIT];
  assign system_control_prot = g0_if.state[PWP_G0_SYS_CTRL_BIT];
  assign power_manager_prot  = g0_if.state[PWP_G0_POWER_BIT];

  assign trace_buffer_prot   = g1_if.state[PWP_G1_TRACE_BIT];
  assign io_port_prot        = g1_if.state[PWP_G1_IO_PORT_BIT];
  assign flash_ctrl_prot     = g1_if.state[PWP_G1_FLASH_BIT];
  assign debug_service_prot  = g1_if.state[PWP_G1_DEBUG_BIT];

endmodule : pwp_top

`default_nettype wire

// File: tb/pwp_top_assertions.sv
// Port-level assertions for the write-protect controller
`timescale 1ns/1ps
`default_nettype none
module pwp_top_chk
  import pwp_pkg::*;
(
  input wire logic                            ref_clk,
  input wire logic                            sys_rst,
  input wire logic                            psel_grp0,
  input wire logic                            psel_grp1,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [pwp_pkg::PWP_ADDR_W-1:0]  paddr,
  input wire logic [pwp_pkg::PWP_DATA_W-1:0]  pwdata,
  input wire logic [pwp_pkg::PWP_STRB_W-1:0]  pstrb,
  input wire logic [pwp_pkg::PWP_DATA_W-1:0]  prdata,
  input wire logic                            pslverr,
  input wire logic [pwp_pkg::PWP_DATA_W-1:0]  group0_protect,
  input wire logic [pwp_pkg::PWP_DATA_W-1:0]  group1_protect
);
  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic one_sel, wr_acc, w0c, w0s, w1c, setup, bad_adr, rd_ok;
  assign one_sel = psel_grp0 ^ psel_grp1;
  assign wr_acc  = one_sel & penable & pwrite & pstrb[0];
  assign w0c     = wr_acc & psel_grp0 & (paddr == PWP_OFF_CLEAR);
  assign w0s     = wr_acc & psel_grp0 & (paddr == PWP_OFF_SET);
  assign w1c     = wr_acc & psel_grp1 & (paddr == PWP_OFF_CLEAR);
  assign setup   = one_sel & ~penable;
  // Group 1 owns only the clear word, so 0x04 is refused there
  assign bad_adr = setup & (paddr != PWP_OFF_CLEAR)
                 & (psel_grp1 | (paddr != PWP_OFF_SET));
  assign rd_ok   = setup & ~pwrite & (pstrb == 4'h0) & ~bad_adr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_reset_values: assert property (
    $past(sys_rst) |-> group0_protect == PWP_G0_RESET
                       && group1_protect == PWP_G1_RESET)
    else $error("protection state wrong after reset");
  a_zero_write: assert property (
    penable && pwrite && (!pstrb[0] || pwdata[7:0] == 8'h00)
    |=> $stable(group0_protect) && $stable(group1_protect))
    else $error("zero write changed protection");
  a_g0_clear: assert property (
    w0c |=> group0_protect ==
      ($past(group0_protect) & ~($past(pwdata) & PWP_G0_MASK)))
    else $error("group 0 clear word misapplied");
  a_g0_set: assert property (
    w0s |=> group0_protect ==
      ($past(group0_protect) | ($past(pwdata) & PWP_G0_MASK)))
    else $error("group 0 set word misapplied");
  a_g1_clear: assert property (
    w1c |=> group1_protect ==
      ($past(group1_protect) & ~($past(pwdata) & PWP_G1_MASK)))
    else $error("group 1 clear word misapplied");
  a_unused_bits: assert property (
    (group0_protect & ~PWP_G0_MASK) == 32'h0
    && (group1_protect & ~PWP_G1_MASK) == 32'h0)
    else $error("unused protection bit set");
  a_bad_addr: assert property (
    bad_adr |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  a_read_g0: assert property (
    rd_ok && psel_grp0 |=> !pslverr && prdata == $past(group0_protect))
    else $error("group 0 read data wrong");
  a_read_g1: assert property (
    rd_ok && psel_grp1 |=> !pslverr && prdata == $past(group1_protect))
    else $error("group 1 read data wrong");
  a_strobe_read: assert property (
    setup && !pwrite && pstrb != 4'h0 |=> pslverr && prdata == 32'h0)
    else $error("read with byte strobes not refused");
  a_both_sel: assert property (
    psel_grp0 && psel_grp1 && !penable |=> pslverr && prdata == 32'h0)
    else $error("double select not refused");
  a_refused_write: assert property (
    (bad_adr || (psel_grp0 && psel_grp1 && !penable)) && pwrite
    |=> ##1 $stable(group0_protect) && $stable(group1_protect))
    else $error("refused write changed protection");
endmodule : pwp_top_chk
`default_nettype wire

// File: tb/pwp_top_tb.sv
// Self-checking bench for the write-protect controller
`timescale 1ns/1ps
`default_nettype none
module pwp_top_tb;
  import pwp_pkg::*;
  logic        ref_clk, sys_rst, psel_grp0, psel_grp1, penable, pwrite;
  logic        pready, pslverr, er;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  wire  [3:0]  f1;
  wire  [5:0]  f0;
  logic [31:0] pwdata, prdata, g0, g1, rd, exp0;
  int          err_count, total_checks, cyc;
  pwp_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel_grp0(psel_grp0), .psel_grp1(psel_grp1), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .group0_protect(g0), .group1_protect(g1),
    .irq_line_ctrl_prot(f0[5]), .calendar_prot(f0[4]),
    .watchdog_prot(f0[3]), .clock_gen_prot(f0[2]),
    .system_control_prot(f0[1]), .power_manager_prot(f0[0]),
    .trace_buffer_prot(f1[3]), .io_port_prot(f1[2]),
    .flash_ctrl_prot(f1[1]), .debug_service_prot(f1[0]));
  // ------------------------------------------------------------
  // Clock, timeout and checking tasks
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Whole run needs under a hundred cycles; a hang stops here
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("MISMATCH t=%0t run timed out", $time);
      finish_test();
    end
  end
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  // Leaves the request standing so the next call runs back to back
  task automatic xfer(input logic [1:0] s, input logic w,
                      input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st);
    {psel_grp1, psel_grp0} = s;
    pwrite = w;
    paddr = a;
    pwdata = d;
    pstrb = st;
    penable = 1'b0;
    @(posedge ref_clk);
    #1 penable = 1'b1;
    @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    #1;
  endtask : xfer
  task automatic wr(input logic [1:0] s, input logic [7:0] a,
                    input logic [31:0] d);
    xfer(s, 1'b1, a, d, 4'h1);
  endtask : wr
  task automatic rdc(input logic [1:0] s, input logic [7:0] a,
                     input logic [31:0] exp, input logic e);
    xfer(s, 1'b0, a, 32'h0, 4'h0);
    chk32(rd, exp);
    chk1(er, e);
  endtask : rdc
  task automatic do_reset;
    {psel_grp1, psel_grp0, penable} = 3'h0;
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
  endtask : do_reset
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    pwrite = 1'b0;
    {paddr, pwdata, pstrb} = 44'h0;
    do_reset();
    rdc(2'h1, PWP_OFF_CLEAR, 32'h0, 1'b0);
    rdc(2'h1, PWP_OFF_SET, 32'h0, 1'b0);
    rdc(2'h2, PWP_OFF_CLEAR, 32'h2, 1'b0);
    chk32({28'h0, f1}, 32'h1);
    chk1(pready, 1'b1);
    exp0 = 32'h0;
    for (int i = 1; i <= 6; i++) begin
      wr(2'h1, PWP_OFF_SET, 32'h1 << i);
      exp0 = exp0 | (32'h1 << i);
      rdc(2'h1, PWP_OFF_CLEAR, exp0, 1'b0);
      chk32({25'h0, f0, 1'b0}, exp0);
      chk32(g0, exp0);
    end
    wr(2'h1, PWP_OFF_CLEAR, 32'h0);
    rdc(2'h1, PWP_OFF_SET, 32'h7e, 1'b0);
    xfer(2'h1, 1'b1, PWP_OFF_CLEAR, 32'h10, 4'h0);
    rdc(2'h1, PWP_OFF_SET, 32'h7e, 1'b0);
    wr(2'h1, PWP_OFF_CLEAR, 32'h10);
    rdc(2'h1, PWP_OFF_CLEAR, 32'h6e, 1'b0);
    chk1(f0[3], 1'b0);
    wr(2'h1, PWP_OFF_SET, 32'hffff_ffff);
    rdc(2'h1, PWP_OFF_SET, 32'h7e, 1'b0);
    wr(2'h1, PWP_OFF_CLEAR, 32'hffff_ffff);
    rdc(2'h1, PWP_OFF_CLEAR, 32'h0, 1'b0);
    wr(2'h3, PWP_OFF_SET, 32'h7e);
    chk1(er, 1'b1);
    chk32(g0, 32'h0);
    wr(2'h2, PWP_OFF_SET, 32'hff);
    chk1(er, 1'b1);
    rdc(2'h2, PWP_OFF_CLEAR, 32'h2, 1'b0);
    wr(2'h2, PWP_OFF_CLEAR, 32'h2);
    rdc(2'h2, PWP_OFF_CLEAR, 32'h0, 1'b0);
    chk32({28'h0, f1}, 32'h0);
    rdc(2'h1, 8'h08, 32'h0, 1'b1);
    rdc(2'h3, PWP_OFF_CLEAR, 32'h0, 1'b1);
    xfer(2'h1, 1'b0, PWP_OFF_CLEAR, 32'h0, 4'h1);
    chk32(rd, 32'h0);
    chk1(er, 1'b1);
    wr(2'h1, PWP_OFF_SET, 32'h7e);
    do_reset();
    rdc(2'h2, PWP_OFF_CLEAR, 32'h2, 1'b0);
    rdc(2'h1, PWP_OFF_SET, 32'h0, 1'b0);
    finish_test();
  end
endmodule : pwp_top_tb
bind pwp_top pwp_top_chk chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel_grp0(psel_grp0),
  .psel_grp1(psel_grp1), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pslverr(pslverr), .group0_protect(group0_protect),
  .group1_protect(group1_protect));
`default_nettype wire
